// ===== rtl/fbs_cycle.sv
// One asynchronous flash bus cycle: setup, strobe pulse, recovery.
// Assumes dq_in is already synchronous to clock.
`timescale 1ns/100ps
module fbs_cycle import fbs_pkg::*; (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Request side.
  input wire logic start,
  input wire fbs_req_s req,
  output logic done,
  output logic [FL_DATA_W-1:0] rdata,
  // Flash side.
  output fbs_pins_s pins,
  input wire logic [FL_DATA_W-1:0] dq_in
);

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_RECOV} cph_e;

  // Whole state of the cycle engine.
  typedef struct packed {
    cph_e ph;
    logic [7:0] cnt;
    logic done;
    logic [FL_DATA_W-1:0] rdata;
    fbs_pins_s pins;
  } cyc_s;

  cyc_s r, next_r;

  // Phase sequencing; every cycle ends with all strobes high.
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.ph)
      C_IDLE: begin
        if (start) begin
          next_r.ph = C_SETUP;
          next_r.cnt = SETUP_CYC;
          next_r.pins.ce_n = 1'b0;
          next_r.pins.addr = req.addr;
          next_r.pins.dq_out = req.data;
          next_r.pins.dq_oe = req.wr;
        end
      end
      C_SETUP: begin
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          next_r.ph = C_PULSE;
          next_r.cnt = PULSE_CYC;
          next_r.pins.we_n = ~r.pins.dq_oe;
          next_r.pins.oe_n = r.pins.dq_oe;
        end
      end
      C_PULSE: begin
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          // Read data is caught just before the strobe rises.
          if (!r.pins.dq_oe) begin
            next_r.rdata = dq_in;
          end
          next_r.ph = C_RECOV;
          next_r.cnt = RECOVER_CYC;
          next_r.pins.we_n = 1'b1;
          next_r.pins.oe_n = 1'b1;
        end
      end
      C_RECOV: begin
        // The chip enable rises too, so back-to-back reads are split.
        next_r.pins.ce_n = 1'b1;
        next_r.pins.dq_oe = 1'b0;
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          next_r.ph = C_IDLE;
          next_r.done = 1'b1;
        end
      end
      default: next_r.ph = C_IDLE;
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r <= '0;
      r.ph <= C_IDLE;
      r.pins.ce_n <= 1'b1;
      r.pins.oe_n <= 1'b1;
      r.pins.we_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;
  assign rdata = r.rdata;
  assign pins = r.pins;

endmodule

// ===== rtl/fbs_host.sv
// Host controller for a NOR flash: suspend, resume, unlock bypass,
// accelerated program and write-status polling through the flash pins.
// Assumes the flash pins meet this clock and a level shifter turns
// accel_high_level into the high voltage on the accelerate pin.
//
// Behaviour
// (RL1) Suspend program: one write of 00B0h.
// (RL2) Resume program: one write of 0030h.
// (RL3) High accelerate level enters bypass automatically.
// (RL4) No sector accelerated more than ten times.
// (RL5) Abort recovery in bypass uses full three writes.
// (RL6) Sectors unlocked before raising accelerate level.
// (RL7) Accelerate level only during accelerated programming.
// (RL8) Bypass entry: AA, 55, 20 at unlock addresses.
// (RL9) Bypass program: setup A0 then data write.
// (RL10) In bypass, device honours only bypass commands.
// (RL11) Bypass exit: 90h then 00h writes.
// (RL12) Polling bit valid after final write strobe.
// (RL13) Program polling shows inverted bit seven.
// (RL14) Erase polling reads zero until done.
// (RL15) All-protected erase toggles about 100 us.
// (RL16) Partly protected erase skips protected sectors.
// (RL17) Protected program toggles about one microsecond.
// (RL18) Polling bit may lead the other bits.
// (RL19) Toggle bit inverts each read while busy.
// (RL20) Toggle needs output or chip enable pulsed.
// (RL21) Erase suspend stops toggling until suspend-program.
// (RL22) Sector toggle marks sectors selected for erase.
// (RL23) Timing-limit flag set means reset needed.
// (RL24) Buffer-abort flag set means abort reset needed.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
module fbs_host import fbs_pkg::*; #(
  parameter int SECT_W = 4,
  parameter logic [15:0] POLL_LIMIT = 16'hffff
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Software register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Flash pins.
  output fbs_pins_s pins,
  input wire logic [FL_DATA_W-1:0] dq_in,
  output logic accel_high_level
);

  localparam int NSECT = 1 << SECT_W;

  typedef enum logic [2:0] {
    S_IDLE, S_ACC_UP, S_SEND, S_SEND_WAIT, S_RD, S_RD_WAIT, S_EVAL,
    S_ACC_DOWN
  } hst_e;

  // Whole state of the host sequencer.
  typedef struct packed {
    hst_e st;
    fbs_cmd_e cmd;
    logic [1:0] step;
    logic rd_idx;
    logic recheck;
    logic [FL_ADDR_W-1:0] addr;
    logic [FL_DATA_W-1:0] data;
    logic [FL_DATA_W-1:0] prev;
    logic [FL_DATA_W-1:0] last;
    logic [15:0] polls;
    logic [7:0] settle;
    logic busy;
    logic done;
    logic err_to;
    logic err_ab;
    logic err_ref;
    logic bypass;
    logic susp;
    logic accel;
    logic unlocked;
    logic sect_tog;
    logic start;
    fbs_req_s req;
    logic [31:0] rdata;
    logic [NSECT-1:0][3:0] acc_cnt;
  } hst_s;

  hst_s r, next_r;
  logic cyc_done;
  logic [FL_DATA_W-1:0] cyc_rdata;
  fbs_req_s cur;
  logic cur_last;
  logic [SECT_W-1:0] sect;

  // The sector index is the top of the flash address.
  assign sect = r.addr[FL_ADDR_W-1 -: SECT_W];

  // Write step table: which word goes where for each command and step.
  always_comb begin
    cur = '{wr: 1'b1, addr: A_ANY, data: RST_WORD};
    cur_last = 1'b1;
    case (r.cmd)
      // (RL1) suspend single write
      FBS_SUSPEND: cur.data = D_SUSPEND;
      // (RL2) resume single write
      FBS_RESUME: cur.data = D_RESUME;
      // (RL8) three-write bypass entry
      FBS_BYP_ENTRY, FBS_ABORT_RST: begin
        cur_last = (r.step == 2'd2);
        case (r.step)
          2'd0: cur = '{wr: 1'b1, addr: A_UNLOCK1, data: D_UNLOCK1};
          2'd1: cur = '{wr: 1'b1, addr: A_UNLOCK2, data: D_UNLOCK2};
          default: begin
            cur.addr = A_UNLOCK1;
            // (RL5) full abort reset sequence
            cur.data = (r.cmd == FBS_ABORT_RST) ? D_ABORT_RST
                                                : D_BYP_ENTRY;
          end
        endcase
      end
      // (RL9) two-write bypass program
      FBS_BYP_PROG, FBS_ACC_PROG: begin
        cur_last = (r.step == 2'd1);
        if (r.step == 2'd0) begin
          cur.data = D_PROG_SETUP;
        end else begin
          cur.addr = r.addr;
          cur.data = r.data;
        end
      end
      // (RL11) two-write bypass exit
      FBS_BYP_EXIT: begin
        cur_last = (r.step == 2'd1);
        cur.data = (r.step == 2'd0) ? D_BYP_EXIT1 : D_BYP_EXIT2;
      end
      // Polls and plain reads only read at the given address.
      default: begin
        cur.wr = 1'b0;
        cur.addr = r.addr;
      end
    endcase
  end

  // Sequencer and register file.
  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    // Read data stand in the cycle after the read strobe only.
    next_r.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        R_CMD: next_r.rdata = {28'h0000000, r.cmd};
        R_ADDR: next_r.rdata = {6'h00, r.addr};
        R_DATA: next_r.rdata = {16'h0000, r.data};
        R_STATUS: next_r.rdata = {23'h000000, r.sect_tog, r.accel,
                                  r.susp, r.bypass, r.err_ref, r.err_ab,
                                  r.err_to, r.done, r.busy};
        R_RDATA: next_r.rdata = {16'h0000, r.last};
        R_ACCCFG: next_r.rdata = {31'h00000000, r.unlocked};
        R_ACCCNT: next_r.rdata = {28'h0000000, r.acc_cnt[sect]};
        default: next_r.rdata = '0;
      endcase
    end
    if (reg_wr) begin
      case (reg_addr)
        R_ADDR: begin
          if (!r.busy) begin
            next_r.addr = reg_wdata[FL_ADDR_W-1:0];
          end
        end
        R_DATA: begin
          if (!r.busy) begin
            next_r.data = reg_wdata[FL_DATA_W-1:0];
          end
        end
        R_ACCCFG: begin
          // (RL6) software vouches sectors unlocked
          next_r.unlocked = reg_wdata[0];
        end
        R_CMD: begin
          if (r.busy) begin
            // A command while busy is dropped and flagged.
            next_r.err_ref = 1'b1;
          end else begin
            next_r.cmd = fbs_cmd_e'(reg_wdata[3:0]);
            next_r.step = 2'd0;
            next_r.rd_idx = 1'b0;
            next_r.recheck = 1'b0;
            next_r.polls = 16'h0000;
            next_r.done = 1'b0;
            next_r.err_to = 1'b0;
            next_r.err_ab = 1'b0;
            next_r.err_ref = 1'b0;
            next_r.sect_tog = 1'b0;
            next_r.busy = 1'b1;
            next_r.st = S_SEND;
            case (fbs_cmd_e'(reg_wdata[3:0]))
              // (RL10) bypass-only commands need bypass
              FBS_BYP_PROG, FBS_BYP_EXIT: begin
                if (!r.bypass) begin
                  next_r.busy = 1'b0;
                  next_r.err_ref = 1'b1;
                  next_r.st = S_IDLE;
                end
              end
              FBS_ACC_PROG: begin
                // (RL4) per-sector accelerate limit
                if (!r.unlocked || r.acc_cnt[sect] >= ACC_LIMIT) begin
                  next_r.busy = 1'b0;
                  next_r.err_ref = 1'b1;
                  next_r.st = S_IDLE;
                end else begin
                  next_r.st = S_ACC_UP;
                  next_r.settle = ACC_SETTLE_CYC;
                end
              end
              FBS_POLL, FBS_READ: next_r.st = S_RD;
              FBS_SUSPEND, FBS_RESUME, FBS_BYP_ENTRY,
              FBS_ABORT_RST: next_r.st = S_SEND;
              default: begin
                next_r.busy = 1'b0;
                next_r.err_ref = 1'b1;
                next_r.st = S_IDLE;
              end
            endcase
          end
        end
        default: ;
      endcase
    end
    case (r.st)
      S_IDLE: ;
      S_ACC_UP: begin
        // (RL7) level raised only for this program
        next_r.accel = 1'b1;
        next_r.settle = r.settle - 8'h01;
        if (r.settle == 8'h01) begin
          // (RL3) device now in bypass by itself
          next_r.st = S_SEND;
        end
      end
      S_SEND: begin
        next_r.start = 1'b1;
        next_r.req = cur;
        next_r.st = S_SEND_WAIT;
      end
      S_SEND_WAIT: begin
        if (cyc_done) begin
          if (!cur_last) begin
            next_r.step = r.step + 2'd1;
            next_r.st = S_SEND;
          end else begin
            case (r.cmd)
              FBS_SUSPEND: begin
                next_r.susp = 1'b1;
                next_r.st = S_IDLE;
              end
              FBS_BYP_ENTRY: begin
                next_r.bypass = 1'b1;
                next_r.st = S_IDLE;
              end
              FBS_BYP_EXIT: begin
                next_r.bypass = 1'b0;
                next_r.st = S_IDLE;
              end
              FBS_RESUME: begin
                next_r.susp = 1'b0;
                next_r.st = S_RD;
              end
              FBS_ABORT_RST: next_r.st = S_IDLE;
              // (RL12) status polled after last strobe
              default: next_r.st = S_RD;
            endcase
            if (next_r.st == S_IDLE) begin
              next_r.busy = 1'b0;
              next_r.done = 1'b1;
            end
          end
        end
      end
      S_RD: begin
        // (RL20) each read is its own chip enable pulse
        next_r.start = 1'b1;
        // Status reads go to the target address, never a command word.
        next_r.req = '{wr: 1'b0, addr: r.addr, data: RST_WORD};
        next_r.st = S_RD_WAIT;
      end
      S_RD_WAIT: begin
        if (cyc_done) begin
          if (r.cmd == FBS_READ) begin
            next_r.last = cyc_rdata;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.st = S_IDLE;
          end else if (!r.rd_idx) begin
            next_r.prev = cyc_rdata;
            next_r.rd_idx = 1'b1;
            next_r.st = S_RD;
          end else begin
            next_r.last = cyc_rdata;
            next_r.st = S_EVAL;
          end
        end
      end
      S_EVAL: begin
        // (RL22) sector toggle kept for software
        if (r.prev[B_SECT_TOG] != r.last[B_SECT_TOG]) begin
          next_r.sect_tog = 1'b1;
        end
        // (RL19) stable toggle bit means finished
        if (r.prev[B_TOGGLE] == r.last[B_TOGGLE]) begin
          next_r.st = r.accel ? S_ACC_DOWN : S_IDLE;
        end else if (r.recheck) begin
          // Still toggling after a flag: the operation failed.
          // (RL23) timing-limit flag reported
          next_r.err_to = r.last[B_TLIMIT];
          // (RL24) buffer-abort flag reported
          next_r.err_ab = r.last[B_ABORT];
          next_r.st = r.accel ? S_ACC_DOWN : S_IDLE;
        end else if (r.last[B_TLIMIT] || r.last[B_ABORT]) begin
          // The toggle may stop just as a flag rises, so look again.
          next_r.recheck = 1'b1;
          next_r.prev = r.last;
          next_r.st = S_RD;
        end else if (r.polls == POLL_LIMIT) begin
          next_r.err_to = 1'b1;
          next_r.st = r.accel ? S_ACC_DOWN : S_IDLE;
        end else begin
          // Start again with a fresh pair of reads.
          next_r.polls = r.polls + 16'h0001;
          next_r.rd_idx = 1'b0;
          next_r.st = S_RD;
        end
        if (next_r.st == S_IDLE) begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end
        if (next_r.st == S_ACC_DOWN) begin
          next_r.settle = ACC_SETTLE_CYC;
        end
      end
      S_ACC_DOWN: begin
        // (RL7) level dropped once the program ends
        next_r.accel = 1'b0;
        next_r.settle = r.settle - 8'h01;
        if (r.settle == 8'h01) begin
          // (RL4) one more use charged to the sector
          next_r.acc_cnt[sect] = r.acc_cnt[sect] + 4'h1;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.st = S_IDLE;
        end
      end
      default: next_r.st = S_IDLE;
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= S_IDLE;
      r.cmd <= FBS_SUSPEND;
    end else begin
      r <= next_r;
    end
  end

  // Bus cycle engine for the flash strobes.
  fbs_cycle u_cycle (
    .clock(clock),
    .rst_n(rst_n),
    .start(r.start),
    .req(r.req),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pins(pins),
    .dq_in(dq_in)
  );

  assign reg_rdata = r.rdata;
  assign accel_high_level = r.accel;

endmodule

// ===== rtl/fbs_pkg.sv
// Shared constants and carriers for the flash bypass and status host.
// Assumes a 16-bit word-wide parallel NOR flash on asynchronous strobes.
package fbs_pkg;

  // Flash word-address and data widths, in bits.
  localparam int FL_ADDR_W = 26;
  localparam int FL_DATA_W = 16;

  // Clock period and strobe timing in nanoseconds.
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETUP_NS = 10;
  localparam int PULSE_NS = 40;
  localparam int RECOVER_NS = 20;
  localparam int ACC_SETTLE_NS = 250;

  // Least times round up to whole cycles.
  localparam logic [7:0] SETUP_CYC =
    8'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PULSE_CYC =
    8'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RECOVER_CYC =
    8'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ACC_SETTLE_CYC =
    8'((ACC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Command words and unlock addresses.
  localparam logic [15:0] D_SUSPEND = 16'h00b0;
  localparam logic [15:0] D_RESUME = 16'h0030;
  localparam logic [15:0] D_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] D_UNLOCK2 = 16'h0055;
  localparam logic [15:0] D_BYP_ENTRY = 16'h0020;
  localparam logic [15:0] D_PROG_SETUP = 16'h00a0;
  localparam logic [15:0] D_BYP_EXIT1 = 16'h0090;
  localparam logic [15:0] D_BYP_EXIT2 = 16'h0000;
  localparam logic [15:0] D_ABORT_RST = 16'h00f0;
  localparam logic [25:0] A_UNLOCK1 = 26'h0000555;
  localparam logic [25:0] A_UNLOCK2 = 26'h00002aa;
  localparam logic [25:0] A_ANY = 26'h0000000;

  // Status bit positions on the flash data bus.
  localparam int B_POLL = 7;
  localparam int B_TOGGLE = 6;
  localparam int B_TLIMIT = 5;
  localparam int B_SECT_TOG = 2;
  localparam int B_ABORT = 1;

  // Accelerated programs allowed per sector.
  localparam logic [3:0] ACC_LIMIT = 4'ha;

  // Register offsets of the software port.
  localparam logic [7:0] R_CMD = 8'h00;
  localparam logic [7:0] R_ADDR = 8'h04;
  localparam logic [7:0] R_DATA = 8'h08;
  localparam logic [7:0] R_STATUS = 8'h0c;
  localparam logic [7:0] R_RDATA = 8'h10;
  localparam logic [7:0] R_ACCCFG = 8'h14;
  localparam logic [7:0] R_ACCCNT = 8'h18;

  // Reset values.
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Software commands written to the command register.
  typedef enum logic [3:0] {
    FBS_SUSPEND, FBS_RESUME, FBS_BYP_ENTRY, FBS_BYP_PROG,
    FBS_BYP_EXIT, FBS_ABORT_RST, FBS_POLL, FBS_READ, FBS_ACC_PROG
  } fbs_cmd_e;

  // One flash bus cycle request.
  typedef struct packed {
    logic wr;
    logic [FL_ADDR_W-1:0] addr;
    logic [FL_DATA_W-1:0] data;
  } fbs_req_s;

  // Flash pins driven by the host.
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [FL_ADDR_W-1:0] addr;
    logic [FL_DATA_W-1:0] dq_out;
    logic dq_oe;
  } fbs_pins_s;

endpackage

// ===== verif/fbs_flash_model.sv
// Behavioural flash: command decode, bypass state and status bits.
// Assumes the host pins change only just after the bench clock edge.
`timescale 1ns/100ps
module fbs_flash_model import fbs_pkg::*; (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Host pins.
  input wire fbs_pins_s pins,
  input wire logic accel_high_level,
  // Fault knob: bit1 sticks with timing flag, bit0 with abort flag.
  input wire logic [1:0] stuck,
  // Data bus back to the host.
  output logic [15:0] dq
);
  // Completed writes as {addr, data}, for the bench to inspect.
  logic [41:0] wlog[$];
  // Last two writes and the current one.
  logic [41:0] h1, h2, cur;
  logic we_q, oe_q, bypass, setup, tog;
  // Reads left before a program ends, and the word programmed.
  logic [1:0] busy;
  logic [15:0] md;
  logic [25:0] ma;
  // Decode on the rising write strobe, answer on the falling read.
  always @(posedge clock) begin
    we_q <= pins.we_n;
    oe_q <= pins.oe_n;
    cur = {pins.addr, pins.dq_out};
    if (!rst_n) begin
      {bypass, setup, busy, tog, h1, h2} <= '0;
      md <= 16'hffff;
      ma <= 26'h0;
      dq <= 16'h0;
    end else if (!we_q && pins.we_n) begin
      wlog.push_back(cur);
      h1 <= cur;
      h2 <= h1;
      if ({h2, h1} == {A_UNLOCK1, D_UNLOCK1, A_UNLOCK2, D_UNLOCK2}
          && cur == {A_UNLOCK1, D_BYP_ENTRY})
        bypass <= 1'b1;
      else if (setup) begin
        {ma, md} <= cur;
        busy <= 2'd3;
        setup <= 1'b0;
      end else if ((bypass || accel_high_level)
                   && cur[15:0] == D_PROG_SETUP)
        setup <= 1'b1;
      else if (h1[15:0] == D_BYP_EXIT1 && cur[15:0] == D_BYP_EXIT2)
        bypass <= 1'b0;
      else if (cur[15:0] == D_SUSPEND)
        busy <= 2'd0;
      else if (cur[15:0] == D_RESUME)
        busy <= 2'd3;
    end else if (oe_q && !pins.oe_n && !pins.ce_n) begin
      if (busy != 2'd0 || stuck != 2'd0) begin
        tog <= ~tog;
        busy <= busy - {1'b0, stuck == 2'd0};
        dq <= {md[15:8], ~md[7], ~tog, stuck[1], 3'b0, stuck[0], 1'b0};
      end else
        dq <= (pins.addr == ma) ? md : 16'hffff;
    end else if (pins.oe_n)
      // A released bus does not keep the last value; it flips each cycle.
      dq <= ~dq;
  end
endmodule

// ===== verif/fbs_sva.sv
// Checker for the flash host: strobe shapes and bus ownership.
// Assumes it is bound to fbs_host and sees only its ports.
`timescale 1ns/100ps
module fbs_sva import fbs_pkg::*; (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Flash pins.
  input wire fbs_pins_s pins,
  input wire logic accel_high_level
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Cycles spent at the high level; saturates so it never wraps.
  logic [7:0] acc_cnt;
  // The count restarts each time the level drops.
  always_ff @(posedge clock) begin
    if (!rst_n || !accel_high_level) acc_cnt <= 8'h00;
    else if (acc_cnt != 8'hff) acc_cnt <= acc_cnt + 8'h01;
  end
  // A strobe held low for ten clocks, then released.
  sequence s_low10(logic s);
    (!s)[*8] ##1 !s ##1 !s ##1 s;
  endsequence
  property p_idle;
    $rose(rst_n) |-> pins.ce_n && pins.oe_n && pins.we_n
      && !pins.dq_oe && !accel_high_level;
  endproperty
  a_idle: assert property (p_idle)
    else $error("pins not idle after reset");
  property p_we;
    $fell(pins.we_n) |-> s_low10(pins.we_n);
  endproperty
  a_we: assert property (p_we)
    else $error("write strobe length wrong");
  property p_oe;
    $fell(pins.oe_n) |-> s_low10(pins.oe_n);
  endproperty
  a_oe: assert property (p_oe)
    else $error("read strobe length wrong");
  property p_gap;
    $rose(pins.oe_n) |=> pins.ce_n;
  endproperty
  a_gap: assert property (p_gap)
    else $error("chip enable held across reads");
  property p_wdrv;
    !pins.we_n |-> pins.dq_oe && !pins.ce_n && pins.oe_n;
  endproperty
  a_wdrv: assert property (p_wdrv)
    else $error("write cycle not driven");
  property p_rdrv;
    !pins.oe_n |-> !pins.dq_oe && pins.we_n && !pins.ce_n;
  endproperty
  a_rdrv: assert property (p_rdrv)
    else $error("read cycle with bus driven");
  // address and data steady in a write
  property p_hold;
    !pins.we_n && !$past(pins.we_n) |->
      $stable(pins.addr) && $stable(pins.dq_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("write address or data moved");
  property p_acc;
    $fell(pins.we_n) && accel_high_level |-> acc_cnt >= 8'd63;
  endproperty
  a_acc: assert property (p_acc)
    else $error("write before accelerate level settled");
endmodule
bind fbs_host fbs_sva u_fbs_sva (
  .clock(clock),
  .rst_n(rst_n),
  .pins(pins),
  .accel_high_level(accel_high_level)
);

// ===== verif/tb_fbs_host.sv
// Self-checking bench for the flash host controller.
// Assumes the flash model answers on dq and the checker is bound.
`timescale 1ns/100ps
module tb_fbs_host import fbs_pkg::*; ();
  logic clock, rst_n, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [15:0] dq_in;
  logic [1:0] stuck;
  logic accel_high_level;
  fbs_pins_s pins;
  int fail_count, checked;
  // Short polling limit keeps fault runs brief.
  fbs_host #(.SECT_W(4), .POLL_LIMIT(16'h0004)) u_fbs_host (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pins(pins), .dq_in(dq_in),
    .accel_high_level(accel_high_level));
  fbs_flash_model u_fbs_flash_model (
    .clock(clock), .rst_n(rst_n), .pins(pins),
    .accel_high_level(accel_high_level), .stuck(stuck), .dq(dq_in));
  // Clock at 250 MHz.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Compare one value.
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Compare one logged flash write.
  task automatic chk_wr(input int i, input logic [25:0] a,
                        input logic [15:0] d);
    checked++;
    if (i >= u_fbs_flash_model.wlog.size() ||
        u_fbs_flash_model.wlog[i] !== {a, d}) begin
      fail_count++;
      $display("[FAIL] write %0d expected %h %h seen %h", i, a, d,
               u_fbs_flash_model.wlog[i]);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd = reg_rdata;
  endtask
  task automatic give_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Issue a command, then wait for busy to drop under a bound.
  task automatic cmd(input logic [3:0] c);
    int n;
    u_fbs_flash_model.wlog.delete();
    wr(R_CMD, {28'h0, c});
    rdr(R_STATUS);
    for (n = 0; n < 3000 && rd[0] !== 1'b0; n++) rdr(R_STATUS);
    if (rd[0] !== 1'b0) begin
      fail_count++;
      $display("[FAIL] busy expected 0 seen %b", rd[0]);
      give_verdict();
    end
  endtask
  task automatic t_reset();
    rdr(R_STATUS);
    chk("status", 32'h0, rd);
    rdr(R_ACCCFG);
    chk("acccfg", 32'h0, rd);
    wr(8'h40, 32'hffff);
    rdr(8'h40);
    chk("unmapped", 32'h0, rd);
    $display("t_reset done");
  endtask
  task automatic t_susp();
    cmd(FBS_SUSPEND);
    chk_wr(0, A_ANY, D_SUSPEND);
    chk("nwr", 32'd1, 32'(u_fbs_flash_model.wlog.size()));
    chk("susp", 32'h42, rd & 32'h7f);
    cmd(FBS_RESUME);
    chk_wr(0, A_ANY, D_RESUME);
    chk("done", 32'h2, rd & 32'h3f);
    $display("t_susp done");
  endtask
  task automatic t_bypass();
    cmd(FBS_BYP_ENTRY);
    chk_wr(0, A_UNLOCK1, D_UNLOCK1);
    chk_wr(1, A_UNLOCK2, D_UNLOCK2);
    chk_wr(2, A_UNLOCK1, D_BYP_ENTRY);
    chk("bypass", 32'h22, rd & 32'h3f);
    wr(R_ADDR, 32'h1234);
    wr(R_DATA, 32'h5a5a);
    cmd(FBS_BYP_PROG);
    chk_wr(0, A_ANY, D_PROG_SETUP);
    chk_wr(1, 26'h1234, 16'h5a5a);
    chk("prog", 32'h22, rd & 32'h3f);
    cmd(FBS_READ);
    rdr(R_RDATA);
    chk("rdata", 32'h5a5a, rd);
    cmd(FBS_BYP_EXIT);
    chk_wr(0, A_ANY, D_BYP_EXIT1);
    chk_wr(1, A_ANY, D_BYP_EXIT2);
    chk("exit", 32'h02, rd & 32'h3f);
    cmd(FBS_BYP_PROG);
    chk("refuse", 32'h10, rd & 32'h30);
    chk("nwr", 32'd0, 32'(u_fbs_flash_model.wlog.size()));
    $display("t_bypass done");
  endtask
  task automatic t_fault();
    @(posedge clock);
    stuck <= 2'b10;
    cmd(FBS_RESUME);
    chk("tlimit", 32'h4, rd & 32'hc);
    @(posedge clock);
    stuck <= 2'b01;
    cmd(FBS_RESUME);
    chk("abort", 32'h8, rd & 32'hc);
    @(posedge clock);
    stuck <= 2'b00;
    cmd(FBS_ABORT_RST);
    chk_wr(0, A_UNLOCK1, D_UNLOCK1);
    chk_wr(1, A_UNLOCK2, D_UNLOCK2);
    chk_wr(2, A_UNLOCK1, D_ABORT_RST);
    $display("t_fault done");
  endtask
  task automatic t_accel();
    wr(R_ADDR, 32'h0c00000);
    cmd(FBS_ACC_PROG);
    chk("locked", 32'h10, rd & 32'h10);
    wr(R_ACCCFG, 32'h1);
    for (int i = 0; i < 10; i++) begin
      wr(R_DATA, i);
      cmd(FBS_ACC_PROG);
      chk_wr(1, 26'h0c00000, 16'(i));
      chk("level", 32'h0, {31'h0, accel_high_level});
      rdr(R_ACCCNT);
      chk("count", 32'(i + 1), rd);
    end
    cmd(FBS_ACC_PROG);
    chk("limit", 32'h10, rd & 32'h10);
    chk("nwr", 32'd0, 32'(u_fbs_flash_model.wlog.size()));
    cmd(FBS_READ);
    rdr(R_RDATA);
    chk("accdata", 32'h9, rd);
    $display("t_accel done");
  endtask
  // Main sequence: reset for four cycles, then every scenario.
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    stuck = 2'b00;
    fail_count = 0;
    checked = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_susp();
    t_bypass();
    t_fault();
    t_accel();
    give_verdict();
  end
endmodule
